// ==== core/audio_tx_defines.svh ====
`ifndef AUDIO_TX_DEFINES_SVH
`define AUDIO_TX_DEFINES_SVH
`define OFS_CTRL 8'h00
`define OFS_CLOCK 8'h04
`define OFS_FRAME 8'h08
`define OFS_WORD 8'h0c
`define OFS_MASK 8'h10
`define OFS_DATA 8'h14
`define CTRL_RUN 0
`define CTRL_SRST 1
`define CTRL_FRST 2
`define CTRL_LVL_DMA 3
`define CTRL_EMP_DMA 4
`define CTRL_AC97 5
`define CTRL_UNDERRUN 6
`define CTRL_LANE 8
`define CTRL_WM_LSB 12
`define CTRL_ACTIVE 16
`define CTRL_EMPTY 17
`define CTRL_READY 18
`define CTRL_CNT_LSB 20
`define CTRL_WMASK 32'h0000_713b
`define CTRL_RST 32'h0000_4000
`define CLK_DIV_LSB 0
`define CLK_POL 8
`define CLK_OUT 9
`define CLK_SYNC 10
`define CLOCK_WMASK 32'h0000_07ff
`define CLOCK_RST 32'h0000_0000
`define FRAME_WPF_LSB 0
`define FRAME_SYNC_LSB 8
`define FRAME_MSB 16
`define FRAME_EARLY 17
`define FRAME_FSLOW 18
`define FRAME_FSOUT 19
`define FRAME_WMASK 32'h000f_1f0f
`define FRAME_RST 32'h0001_1f01
`define WORD_OTHER_LSB 0
`define WORD_FIRST_LSB 8
`define WORD_FBT_LSB 16
`define WORD_WMASK 32'h001f_1f1f
`define WORD_RST 32'h001f_1f1f
`define FIFO_DEPTH 8
`define FIFO_AW 3
`define AC97_BCLK_HZ 12288000
`define AC97_FS_HZ 48000
`define AC97_FRAME_BITS (`AC97_BCLK_HZ / `AC97_FS_HZ)
`define AC97_SLOTS_M1 4'hc
`define AC97_FIRST_M1 5'hf
`define AC97_OTHER_M1 5'h13
`endif

// ==== core/audio_tx_pkg.sv ====
`include "audio_tx_defines.svh"
package audio_tx_pkg;
  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_LEAD = 2'b01, TX_RUN = 2'b10} tx_state_e;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] clock;
    logic [31:0] frame;
    logic [31:0] word;
    logic [15:0] mask;
  } cfg_s;
  typedef struct packed {
    cfg_s cfg;
    tx_state_e state;
    logic active;
    logic ready_seen;
    logic fs_seen;
    logic muted;
    logic underrun;
    logic [3:0] word_idx;
    logic [4:0] bit_cnt;
    logic [4:0] bit_idx;
    logic [31:0] shreg;
    logic [8:0] fpos;
    logic fs_act;
    logic txd;
    logic [31:0] rdata;
    logic slverr;
  } core_s;
  typedef struct packed {
    logic [`FIFO_DEPTH-1:0][31:0] mem;
    logic [`FIFO_AW-1:0] wp;
    logic [`FIFO_AW-1:0] rp;
    logic [`FIFO_AW:0] cnt;
  } fifo_s;
  typedef struct packed {
    logic [7:0] cnt;
    logic lvl;
    logic b1;
    logic b2;
    logic b3;
    logic f1;
    logic f2;
    logic r1;
    logic r2;
  } clkgen_s;
  typedef struct packed {
    logic launch;
    logic sample;
    logic fs;
    logic rx;
  } bit_timing_s;
endpackage : audio_tx_pkg

// ==== core/audio_tx_fifo.sv ====
`timescale 1ns/100ps
`default_nettype none
module audio_tx_fifo
  import audio_tx_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic flush_i,
  input wire logic push_i,
  input wire logic [31:0] din_i,
  input wire logic pop_i,
  output logic [31:0] dout_o,
  output logic [`FIFO_AW:0] cnt_o,
  output logic empty_o,
  output logic full_o
);
  fifo_s st_reg;
  fifo_s st_next;
  logic do_push;
  logic do_pop;

  assign empty_o = st_reg.cnt == 4'h0;
  assign full_o = st_reg.cnt == 4'(`FIFO_DEPTH);
  assign dout_o = st_reg.mem[st_reg.rp];
  assign cnt_o = st_reg.cnt;
  assign do_push = push_i && !full_o;
  assign do_pop = pop_i && !empty_o;

  always_comb
  begin
    st_next = st_reg;
    if (do_push)
    begin
      st_next.mem[st_reg.wp] = din_i;
      st_next.wp = st_reg.wp + 3'h1;
    end
    if (do_pop)
      st_next.rp = st_reg.rp + 3'h1;
    case ({do_push, do_pop})
      2'b10: st_next.cnt = st_reg.cnt + 4'h1;
      2'b01: st_next.cnt = st_reg.cnt - 4'h1;
      default: st_next.cnt = st_reg.cnt;
    endcase
    if (flush_i)
    begin
      st_next.wp = '0;
      st_next.rp = '0;
      st_next.cnt = '0;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end
endmodule : audio_tx_fifo
`default_nettype wire

// ==== core/audio_bit_timing.sv ====
`timescale 1ns/100ps
`default_nettype none
module audio_bit_timing
  import audio_tx_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] div_i,
  input wire logic pol_i,
  input wire logic out_en_i,
  input wire logic bclk_i,
  input wire logic fs_i,
  input wire logic rx_i,
  output logic bclk_o,
  output bit_timing_s tim_o
);
  clkgen_s st_reg;
  clkgen_s st_next;
  logic tick;

  assign tick = st_reg.cnt == div_i;
  assign bclk_o = st_reg.lvl ^ pol_i;
  // driven pin level, or input pin level xor pol, falls: launch; rises: sample
  assign tim_o.launch = out_en_i ? (tick && bclk_o) : ((st_reg.b3 ^ pol_i) && !(st_reg.b2 ^ pol_i));
  assign tim_o.sample = out_en_i ? (tick && !bclk_o) : (!(st_reg.b3 ^ pol_i) && (st_reg.b2 ^ pol_i));
  assign tim_o.fs = st_reg.f2;
  assign tim_o.rx = st_reg.r2;

  always_comb
  begin
    st_next = st_reg;
    st_next.b1 = bclk_i;
    st_next.b2 = st_reg.b1;
    st_next.b3 = st_reg.b2;
    st_next.f1 = fs_i;
    st_next.f2 = st_reg.f1;
    st_next.r1 = rx_i;
    st_next.r2 = st_reg.r1;
    // half period of div+1 cycles gives a bit period of (div+1)*2
    if (out_en_i)
    begin
      st_next.cnt = tick ? 8'h00 : st_reg.cnt + 8'h01;
      if (tick)
        st_next.lvl = !st_reg.lvl;
    end
    else
    begin
      st_next.cnt = 8'h00;
      st_next.lvl = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end
endmodule : audio_bit_timing
`default_nettype wire

// ==== core/audio_tx_framing.sv ====
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "audio_tx_defines.svh"
// Summary of operation
// - sample words of 8, 12, 16, 20, 24 or 32 bits go out serially
// - master clock divider runs whenever the bitclock is made internally
// - internal bitclock is master clock over (divider+1)*2; polarity, direction, mode selectable
// - software reset and fifo reset exist; software pulses reset then flushes fifo
// - level dma request at count <= watermark; optional empty request
// - words per frame equal field plus one; two words for i2s
// - sync lasts field plus one bitclocks, up to 32, whatever the first word's length
// - msb leading select shifts words most significant bit first
// - early sync asserts one bitclock before the frame's first bit
// - sync polarity low inverts the sync; direction out makes it locally
// - first word carries field plus one bits, up to 32
// - later words carry their field plus one bits
// - each word starts shifting at the first shifted bit index
// - word mask bit per slot masks that word; zero mask enables all
// - fifo writes refused until the transmit lane is enabled
// - cleared run enable finishes the frame, then reads back zero
// - run cleared with software reset stops at once
// - dsp framing uses a one bitclock sync, length field zero
// - ac97 bitclock 12.288 mhz and sync 48 khz, 256 bits a frame
// - ac97 waits for codec ready bit before driving data
// - ac97 frames 13 slots: one 16-bit, twelve 20-bit, one fifo word each
// - synchronous mode never selected by transmitter and receiver together
module audio_tx_framing
  import audio_tx_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic bclk_i,
  input wire logic fs_i,
  input wire logic codec_serial_output_i,
  output logic bclk_o,
  output logic bclk_oe_n_o,
  output logic fs_o,
  output logic fs_oe_n_o,
  output logic codec_serial_input_o,
  output logic dma_level_req_o,
  output logic dma_empty_req_o
);
  core_s core_reg;
  core_s core_next;
  bit_timing_s tim;
  logic push;
  logic pop;
  logic flush;
  logic ld;
  logic [3:0] ld_idx;
  logic [31:0] fifo_dout;
  logic [`FIFO_AW:0] fifo_cnt;
  logic fifo_empty;
  logic fifo_full;
  logic run;
  logic srst;
  logic lane;
  logic ac97;
  logic msb;
  logic early;
  logic fs_low;
  logic fs_out;
  logic bclk_out;
  logic [3:0] frame_m1;
  logic [4:0] sync_m1;
  logic [4:0] first_m1;
  logic [4:0] other_m1;
  logic [4:0] first_shifted_bit_index;
  logic [4:0] wlen;
  logic [2:0] wm;
  logic last_bit;
  logic fs_now;
  logic setup;
  logic wr;

  assign run = core_reg.cfg.ctrl[`CTRL_RUN];
  assign srst = core_reg.cfg.ctrl[`CTRL_SRST];
  assign lane = core_reg.cfg.ctrl[`CTRL_LANE];
  assign ac97 = core_reg.cfg.ctrl[`CTRL_AC97];
  assign wm = core_reg.cfg.ctrl[`CTRL_WM_LSB +: 3];
  assign msb = core_reg.cfg.frame[`FRAME_MSB];
  assign fs_low = core_reg.cfg.frame[`FRAME_FSLOW];
  assign first_shifted_bit_index = core_reg.cfg.word[`WORD_FBT_LSB +: 5];
  // ac97 fixes slot layout; codec drives the bitclock, we drive the sync
  assign frame_m1 = ac97 ? `AC97_SLOTS_M1 : core_reg.cfg.frame[`FRAME_WPF_LSB +: 4];
  assign sync_m1 = ac97 ? `AC97_FIRST_M1 : core_reg.cfg.frame[`FRAME_SYNC_LSB +: 5];
  assign early = ac97 || core_reg.cfg.frame[`FRAME_EARLY];
  assign fs_out = ac97 || core_reg.cfg.frame[`FRAME_FSOUT];
  assign bclk_out = !ac97 && core_reg.cfg.clock[`CLK_OUT];
  assign first_m1 = ac97 ? `AC97_FIRST_M1 : core_reg.cfg.word[`WORD_FIRST_LSB +: 5];
  assign other_m1 = ac97 ? `AC97_OTHER_M1 : core_reg.cfg.word[`WORD_OTHER_LSB +: 5];
  assign wlen = (core_reg.word_idx == 4'h0) ? first_m1 : other_m1;
  assign last_bit = core_reg.bit_cnt == 5'h00 && core_reg.word_idx == frame_m1;
  // early sync covers the last bit of the previous frame
  assign fs_now = early ? ((last_bit && run) || core_reg.fpos < {4'h0, sync_m1})
                        : core_reg.fpos <= {4'h0, sync_m1};

  assign setup = psel_i && !penable_i;
  assign wr = psel_i && penable_i && pwrite_i && !core_reg.slverr;
  assign pready_o = psel_i && penable_i;
  assign pslverr_o = psel_i && penable_i && core_reg.slverr;
  assign prdata_o = core_reg.rdata;

  assign bclk_oe_n_o = !bclk_out;
  assign fs_o = core_reg.fs_act ^ fs_low;
  assign fs_oe_n_o = !fs_out;
  assign codec_serial_input_o = core_reg.txd;
  assign dma_level_req_o = lane && core_reg.cfg.ctrl[`CTRL_LVL_DMA] && fifo_cnt <= {1'b0, wm};
  assign dma_empty_req_o = lane && core_reg.cfg.ctrl[`CTRL_EMP_DMA] && fifo_empty;

  audio_bit_timing u_timing (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .div_i(core_reg.cfg.clock[`CLK_DIV_LSB +: 8]),
    .pol_i(core_reg.cfg.clock[`CLK_POL]),
    .out_en_i(bclk_out),
    .bclk_i(bclk_i),
    .fs_i(fs_i),
    .rx_i(codec_serial_output_i),
    .bclk_o(bclk_o),
    .tim_o(tim)
  );

  audio_tx_fifo u_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .flush_i(flush),
    .push_i(push),
    .din_i(pwdata_i),
    .pop_i(pop),
    .dout_o(fifo_dout),
    .cnt_o(fifo_cnt),
    .empty_o(fifo_empty),
    .full_o(fifo_full)
  );

  always_comb
  begin
    core_next = core_reg;
    push = 1'b0;
    pop = 1'b0;
    flush = 1'b0;
    ld = 1'b0;
    ld_idx = 4'h0;
    if (setup)
    begin
      core_next.slverr = 1'b0;
      core_next.rdata = 32'h0000_0000;
      case (paddr_i)
        `OFS_CTRL:
        begin
          core_next.rdata = core_reg.cfg.ctrl;
          // run reads one until the running frame has ended
          core_next.rdata[`CTRL_RUN] = run || core_reg.active;
          core_next.rdata[`CTRL_UNDERRUN] = core_reg.underrun;
          core_next.rdata[`CTRL_ACTIVE] = core_reg.active;
          core_next.rdata[`CTRL_EMPTY] = fifo_empty;
          core_next.rdata[`CTRL_READY] = core_reg.ready_seen;
          core_next.rdata[`CTRL_CNT_LSB +: 4] = fifo_cnt;
        end
        `OFS_CLOCK: core_next.rdata = core_reg.cfg.clock;
        `OFS_FRAME: core_next.rdata = core_reg.cfg.frame;
        `OFS_WORD: core_next.rdata = core_reg.cfg.word;
        `OFS_MASK: core_next.rdata = {16'h0000, core_reg.cfg.mask};
        `OFS_DATA:
        begin
          core_next.rdata = {28'h0000000, fifo_cnt};
          core_next.slverr = pwrite_i && (!lane || fifo_full);
        end
        default: core_next.slverr = 1'b1;
      endcase
    end
    if (wr)
    begin
      case (paddr_i)
        `OFS_CTRL:
        begin
          core_next.cfg.ctrl = pwdata_i & `CTRL_WMASK;
          flush = pwdata_i[`CTRL_FRST];
          if (pwdata_i[`CTRL_UNDERRUN])
            core_next.underrun = 1'b0;
        end
        `OFS_CLOCK: core_next.cfg.clock = pwdata_i & `CLOCK_WMASK;
        `OFS_FRAME: core_next.cfg.frame = pwdata_i & `FRAME_WMASK;
        `OFS_WORD: core_next.cfg.word = pwdata_i & `WORD_WMASK;
        `OFS_MASK: core_next.cfg.mask = pwdata_i[15:0];
        `OFS_DATA: push = 1'b1;
        default: push = 1'b0;
      endcase
    end
    case (core_reg.state)
      TX_IDLE:
      begin
        // outputs drop at a bit edge so a graceful stop keeps its last bit
        if (tim.launch)
        begin
          core_next.fs_act = 1'b0;
          core_next.txd = 1'b0;
          if (run && lane && !srst)
          begin
            core_next.state = TX_LEAD;
            core_next.active = 1'b1;
            core_next.fs_seen = 1'b0;
            core_next.ready_seen = 1'b0;
          end
        end
      end
      TX_LEAD:
      begin
        if (tim.sample && !fs_out && (tim.fs ^ fs_low))
          core_next.fs_seen = 1'b1;
        if (tim.launch)
        begin
          core_next.fs_act = fs_out && early;
          core_next.txd = 1'b0;
          if (fs_out || core_reg.fs_seen)
          begin
            core_next.state = TX_RUN;
            core_next.fpos = 9'h000;
            core_next.fs_seen = 1'b0;
            ld = 1'b1;
          end
        end
      end
      TX_RUN:
      begin
        // codec ready bit is sampled on the early sync bit, one bit before slot zero's first bit
        if (tim.sample && ac97 && core_reg.fpos == 9'h000 && tim.rx)
          core_next.fs_seen = 1'b1;
        if (tim.launch)
        begin
          core_next.fs_act = fs_now;
          core_next.txd = !core_reg.muted && core_reg.shreg[core_reg.bit_idx];
          if (core_reg.bit_cnt != 5'h00)
          begin
            core_next.bit_cnt = core_reg.bit_cnt - 5'h01;
            core_next.bit_idx = msb ? core_reg.bit_idx - 5'h01 : core_reg.bit_idx + 5'h01;
            core_next.fpos = core_reg.fpos + 9'h001;
          end
          else if (last_bit && !run)
          begin
            core_next.state = TX_IDLE;
            core_next.active = 1'b0;
          end
          else
          begin
            ld = 1'b1;
            ld_idx = last_bit ? 4'h0 : core_reg.word_idx + 4'h1;
            core_next.fpos = last_bit ? 9'h000 : core_reg.fpos + 9'h001;
          end
        end
      end
      default: core_next.state = TX_IDLE;
    endcase
    if (ld)
    begin
      if (ld_idx == 4'h0 && ac97)
        core_next.ready_seen = core_reg.ready_seen || core_reg.fs_seen;
      core_next.word_idx = ld_idx;
      core_next.bit_cnt = (ld_idx == 4'h0) ? first_m1 : other_m1;
      core_next.bit_idx = first_shifted_bit_index;
      // masked slots and the ac97 wait leave the fifo untouched
      core_next.muted = core_reg.cfg.mask[ld_idx] || fifo_empty || (ac97 && !core_next.ready_seen);
      pop = !core_next.muted;
      core_next.shreg = fifo_dout;
      // set wins over a clear in the same cycle
      if (fifo_empty && !core_reg.cfg.mask[ld_idx] && !(ac97 && !core_next.ready_seen))
        core_next.underrun = 1'b1;
    end
    if (srst)
    begin
      core_next.state = TX_IDLE;
      core_next.active = 1'b0;
      core_next.fs_act = 1'b0;
      core_next.txd = 1'b0;
      core_next.ready_seen = 1'b0;
      core_next.fs_seen = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      core_reg <= '0;
      core_reg.cfg.ctrl <= `CTRL_RST;
      core_reg.cfg.clock <= `CLOCK_RST;
      core_reg.cfg.frame <= `FRAME_RST;
      core_reg.cfg.word <= `WORD_RST;
    end
    else
      core_reg <= core_next;
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  idle_pins_a: assert property (
    (core_reg.state == TX_IDLE && tim.launch) |=> (!core_reg.fs_act && !core_reg.txd))
    else $error("pins not idle while stopped");
  srst_halt_a: assert property (
    srst |=> (core_reg.state == TX_IDLE && !core_reg.active && !core_reg.txd))
    else $error("software reset did not stop the transmitter");
  lane_gate_a: assert property (
    push |-> (lane && $past(setup)))
    else $error("fifo written while lane disabled");
  level_dma_a: assert property (
    (lane && core_reg.cfg.ctrl[`CTRL_LVL_DMA] && fifo_empty) |-> dma_level_req_o)
    else $error("level request missing on empty fifo");
  empty_dma_a: assert property (
    (dma_empty_req_o) |-> (fifo_cnt == 4'h0 && dma_level_req_o == core_reg.cfg.ctrl[`CTRL_LVL_DMA]))
    else $error("empty request without empty fifo");
  ac97_mute_a: assert property (
    (ac97 && !core_reg.ready_seen && core_reg.state == TX_RUN && tim.launch) |=> !core_reg.txd)
    else $error("data driven before codec ready");
  graceful_end_a: assert property (
    (core_reg.active && !core_next.active && !srst) |-> (last_bit && !run && tim.launch))
    else $error("stopped outside frame end");
  word_len_a: assert property (
    (core_reg.state == TX_RUN && tim.launch && core_reg.bit_cnt == 5'h00 && run)
    |=> (core_reg.bit_cnt == wlen && core_reg.bit_idx == first_shifted_bit_index))
    else $error("word length or start bit wrong");
  frame_wrap_a: assert property (
    (core_reg.state == TX_RUN && tim.launch && last_bit && run) |=> (core_reg.word_idx == 4'h0 && core_reg.fpos == 9'h000))
    else $error("frame did not wrap after last word");
  sync_len_a: assert property (
    (core_reg.state == TX_RUN && tim.launch && !early && core_reg.fpos > {4'h0, sync_m1}) |=> !core_reg.fs_act)
    else $error("sync held too long");
  early_sync_a: assert property (
    (core_reg.state == TX_LEAD && tim.launch && fs_out && early && !srst) |=> core_reg.fs_act)
    else $error("early sync missing before first bit");
  ac97_bits_a: assert property (
    (ac97 && core_reg.state == TX_RUN && last_bit) |-> core_reg.fpos == 9'(`AC97_FRAME_BITS - 1))
    else $error("ac97 frame length wrong");
endmodule : audio_tx_framing
`default_nettype wire

// ==== verif/audio_codec_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module audio_codec_model (
  input wire logic sclk_i,
  input wire logic fs_i,
  input wire logic fs_low_i,
  input wire logic data_i,
  input wire logic ready_i,
  input wire logic [7:0] nbits_i,
  output logic bclk_o,
  output logic rx_o,
  output logic [63:0] frame_o,
  output logic [7:0] fs_len_o,
  output logic [15:0] ones_o,
  output logic [15:0] frames_o
);
  logic [63:0] sr = '0;
  logic [15:0] cnt = '0;
  logic [7:0] run_len = '0;
  logic pact = 1'b0;
  logic arm = 1'b0;
  logic act;
  initial
  begin
    bclk_o = 1'b0;
    frame_o = '0;
    fs_len_o = '0;
    ones_o = '0;
    frames_o = '0;
  end
  // free running, slowed so the pin synchroniser keeps up
  always #200 bclk_o = ~bclk_o;
  assign act = fs_i ^ fs_low_i;
  // ready flag rides under the sync, in the frame's first bits
  assign rx_o = ready_i & act;
  always @(posedge sclk_i)
  begin
    sr <= {sr[62:0], data_i};
    ones_o <= ones_o + 16'(data_i === 1'b1);
    cnt <= (act && !pact) ? 16'h0 : cnt + 16'h1;
    // length latched when the sync ends, so the next frame's start keeps it
    if (act)
      run_len <= pact ? run_len + 8'h1 : 8'h1;
    else if (pact)
      fs_len_o <= run_len;
    // early sync of the next frame may rise on the captured bit itself
    if (arm && nbits_i != 8'h0 && cnt == 16'(nbits_i) - 16'h1)
    begin
      frame_o <= {sr[62:0], data_i};
      frames_o <= frames_o + 16'h1;
    end
    // one capture per sync edge; nbits of zero disarms after an abort
    if (nbits_i == 8'h0 || (arm && cnt == 16'(nbits_i) - 16'h1))
      arm <= 1'b0;
    if (nbits_i != 8'h0 && act && !pact)
      arm <= 1'b1;
    pact <= act;
  end
endmodule : audio_codec_model
`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "audio_tx_defines.svh"
module testbench
  import audio_tx_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic ready = 1'b0;
  logic fs_low = 1'b0;
  logic [7:0] paddr = '0;
  logic [7:0] nbits = 8'd64;
  logic [31:0] pwdata = '0;
  logic [31:0] q;
  logic [31:0] prdata;
  logic pready, pslverr, bclk, bclk_oe_n, fs, fs_oe_n, txd, lvl, emp, cbclk, rx, bclk_pin, fs_pin;
  logic [63:0] frame;
  logic [7:0] fs_len;
  logic [15:0] ones, frames;
  logic [31:0] ws [5] = '{32'h8000_0001, 32'h1234_5678, 32'ha5a5_0ff0, 32'h0f1e_2d3c, 32'h7654_3210};
  int err_total = 0;
  int comparisons = 0;
  always #12.5 clk = ~clk;
  assign bclk_pin = bclk_oe_n ? cbclk : bclk;
  assign fs_pin = fs_oe_n ? fs_low : fs;
  audio_tx_framing dut (.sys_clk_i(clk), .rst_i(rst), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .bclk_i(bclk_pin), .fs_i(fs_pin), .codec_serial_output_i(rx), .bclk_o(bclk), .bclk_oe_n_o(bclk_oe_n),
    .fs_o(fs), .fs_oe_n_o(fs_oe_n), .codec_serial_input_o(txd), .dma_level_req_o(lvl), .dma_empty_req_o(emp));
  audio_codec_model codec (.sclk_i(bclk_pin), .fs_i(fs_pin), .fs_low_i(fs_low), .data_i(txd), .ready_i(ready),
    .nbits_i(nbits), .bclk_o(cbclk), .rx_o(rx), .frame_o(frame), .fs_len_o(fs_len), .ones_o(ones),
    .frames_o(frames));
  task conclude;
    if (err_total == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task chk(input string n, input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s exp %h got %h", n, exp, got);
    end
  endtask : chk
  task xf(input logic wr_en, input logic [7:0] a, input logic [31:0] d, input logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    q = prdata;
    chk("pslverr", 64'(pslverr), 64'(e));
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : xf
  task wr(input logic [7:0] a, input logic [31:0] d);
    xf(1'b1, a, d, 1'b0);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    xf(1'b0, a, 32'h0, 1'b0);
    chk("register", 64'(q & m), 64'(e));
  endtask : rd
  task wf(input int n);
    logic [15:0] f0;
    f0 = frames;
    while (frames != f0 + 16'(n))
      @(posedge clk);
  endtask : wf
  task idle_chk;
    repeat (40)
    begin
      @(posedge clk);
      chk("idle sync", 64'(fs), 64'(fs_low));
      chk("idle data", 64'(txd), 64'h0);
    end
  endtask : idle_chk
  function automatic logic [31:0] rev(input logic [31:0] v, input int n);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < n; i++)
      r[n-1-i] = v[i];
    return r;
  endfunction : rev
  initial
  begin
    repeat (80000) @(posedge clk);
    err_total++;
    conclude();
  end
  initial
  begin
    int t;
    logic [15:0] f;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(`OFS_CTRL, 32'hffff_ffff, `CTRL_RST | (32'h1 << `CTRL_EMPTY));
    rd(`OFS_CLOCK, 32'hffff_ffff, `CLOCK_RST);
    rd(`OFS_FRAME, 32'hffff_ffff, `FRAME_RST);
    rd(`OFS_WORD, 32'hffff_ffff, `WORD_RST);
    chk("sync oe", 64'(fs_oe_n), 64'h1);
    xf(1'b0, 8'h18, 32'h0, 1'b1);
    wr(`OFS_CTRL, 32'h2);
    wr(`OFS_CTRL, 32'h0);
    wr(`OFS_CTRL, 32'h4);
    wr(`OFS_CLOCK, 32'h201);
    wr(`OFS_FRAME, 32'h000b_1f01);
    wr(`OFS_WORD, 32'h001f_1f1f);
    wr(`OFS_MASK, 32'h0);
    xf(1'b1, `OFS_DATA, ws[0], 1'b1);
    wr(`OFS_CTRL, 32'h4118);
    chk("empty req", 64'(emp), 64'h1);
    for (int i = 0; i < 5; i++)
    begin
      wr(`OFS_DATA, ws[i]);
      chk("level req", 64'(lvl), 64'(i < 4));
    end
    chk("empty req", 64'(emp), 64'h0);
    rd(`OFS_CTRL, 32'h00f0_0000, 32'h0050_0000);
    chk("sync oe", 64'(fs_oe_n), 64'h0);
    wr(`OFS_CTRL, 32'h4119);
    wf(1);
    chk("i2s frame", frame, {ws[0], ws[1]});
    chk("i2s sync", 64'(fs_len), 64'd32);
    t = 0;
    @(posedge bclk);
    do
    begin
      @(posedge clk);
      #1;
      t++;
    end
    while (bclk === 1'b1);
    chk("half bit", 64'(t), 64'd2);
    f = frames;
    wr(`OFS_CTRL, 32'h4118);
    rd(`OFS_CTRL, 32'h1, 32'h1);
    do
      xf(1'b0, `OFS_CTRL, 32'h0, 1'b0);
    while (q[0] !== 1'b0);
    chk("last frames", 64'(frames), 64'(f + 16'h1));
    chk("last frame", frame, {ws[2], ws[3]});
    idle_chk();
    wr(`OFS_CTRL, 32'h4119);
    repeat (100) @(posedge clk);
    f = frames;
    wr(`OFS_CTRL, 32'h411a);
    nbits <= 8'd0;
    rd(`OFS_CTRL, 32'h0001_0001, 32'h0);
    idle_chk();
    chk("abandoned", 64'(frames), 64'(f));
    // dsp framing: one bit sync, active low, lsb first, 16 then 12 bits, middle word muted
    wr(`OFS_CTRL, 32'h411c);
    fs_low <= 1'b1;
    wr(`OFS_FRAME, 32'h000e_0002);
    wr(`OFS_WORD, 32'h0000_0f0b);
    wr(`OFS_MASK, 32'h2);
    wr(`OFS_CTRL, 32'h4118);
    chk("idle low sync", 64'(fs), 64'h1);
    wr(`OFS_DATA, 32'hffff_9ab1);
    wr(`OFS_DATA, 32'hffff_fc35);
    nbits <= 8'd40;
    wr(`OFS_CTRL, 32'h4119);
    wf(1);
    chk("dsp frame", 64'(frame[39:0]), (64'(rev(32'h9ab1, 16)) << 24) | 64'(rev(32'hc35, 12)));
    chk("dsp sync", 64'(fs_len), 64'd1);
    wr(`OFS_CTRL, 32'h411e);
    nbits <= 8'd0;
    fs_low <= 1'b0;
    wr(`OFS_FRAME, 32'h000b_0f0c);
    wr(`OFS_WORD, 32'h001f_0f13);
    wr(`OFS_CTRL, 32'h4138);
    chk("bclk oe", 64'(bclk_oe_n), 64'h1);
    repeat (3) wr(`OFS_DATA, 32'hffff_ffff);
    nbits <= 8'd64;
    wr(`OFS_CTRL, 32'h4139);
    f = ones;
    wf(2);
    chk("muted data", 64'(ones), 64'(f));
    rd(`OFS_CTRL, 32'h00f4_0000, 32'h0030_0000);
    ready <= 1'b1;
    wf(4);
    rd(`OFS_CTRL, 32'h0004_0000, 32'h0004_0000);
    // all-ones words: only slot widths 16, 20, 20 reach the line
    chk("ac97 ones", 64'(ones), 64'(f + 16'd56));
    conclude();
  end
endmodule : testbench
`default_nettype wire
